// >>> logic/cdh_pkg.sv
// Constants, register map and types for the codec DMA handshake block.
// Assumes a 50 MHz system clock; offsets are APB byte addresses.
package cdh_pkg;
   // Clock and sample timing
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SAMPLE_RATE_HZ = 48000;
   localparam int SAMPLE_PERIOD_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
   localparam int CAPTURE_PHASE_CYCLES = (SAMPLE_PERIOD_CYCLES * 3) / 4;
   localparam int INIT_TIME_NS = 2000;
   localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_RISE_PERIODS = 2;
   localparam int CAL_BUSY_PERIODS = 384;
   localparam int SAMPLE_BYTES = 4;

   // Register byte offsets
   localparam logic [7:0] CONFIG_OFFSET = 8'h00;
   localparam logic [7:0] BASE_LOW_OFFSET = 8'h04;
   localparam logic [7:0] BASE_HIGH_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;

   // Configuration fields
   localparam int CFG_PLAYBACK_ENABLE = 0;
   localparam int CFG_CAPTURE_ENABLE = 1;
   localparam int CFG_SINGLE_CHANNEL_MODE = 2;
   localparam int CFG_CALIBRATE_REQUEST = 3;
   localparam int CFG_REQUEST_HOLD_DISABLE = 4;
   localparam int CFG_IRQ_PIN_ENABLE = 5;
   localparam int CFG_PLAYBACK_PIO_SELECT = 6;
   localparam int CFG_CAPTURE_PIO_SELECT = 7;
   localparam int CFG_MODE_CHANGE_WINDOW = 8;
   localparam int CFG_W = 9;
   localparam logic [CFG_W-1:0] CFG_RESET = 9'h0C0;

   // Status fields
   localparam int STS_IRQ = 0;
   localparam int STS_CALIBRATION_BUSY = 1;
   localparam int STS_PLAYBACK_REQUEST = 2;
   localparam int STS_CAPTURE_REQUEST = 3;
   localparam logic [7:0] BASE_RESET = 8'h00;
   localparam logic [7:0] BUSY_CODE = 8'h80;

   typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT, CAL_RUN} cdh_cal_t;
endpackage : cdh_pkg

// >>> logic/cdh_host_if.sv
// Synchronised host strobes, acknowledges and data byte.
// Driven by the synchroniser, read by the DMA core.
`timescale 1ns/10ps
`default_nettype none
interface cdh_host_if;
   logic rd_n;
   logic wr_n;
   logic play_ack_n;
   logic cap_ack_n;
   logic [7:0] data;
   modport sync (output rd_n, output wr_n, output play_ack_n, output cap_ack_n, output data);
   modport core (input rd_n, input wr_n, input play_ack_n, input cap_ack_n, input data);
endinterface : cdh_host_if
`default_nettype wire

// >>> logic/cdh_sync.sv
// Two-flop synchroniser for the asynchronous host bus pins.
// Strobes and acknowledges idle high; first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module cdh_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Raw pins
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic play_ack_n,
   input wire logic cap_ack_n,
   input wire logic [7:0] data,
   // Synchronised side
   cdh_host_if.sync host
);
   typedef struct packed {
      logic [11:0] s1;
      logic [11:0] s2;
   } cdh_sync_t;
   cdh_sync_t st;
   cdh_sync_t next_st;

   always_comb begin
      next_st.s1 = {rd_n, wr_n, play_ack_n, cap_ack_n, data};
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= {12'hF00, 12'hF00};
      end else begin
         st <= next_st;
      end
   end

   assign host.rd_n = st.s2[11];
   assign host.wr_n = st.s2[10];
   assign host.play_ack_n = st.s2[9];
   assign host.cap_ack_n = st.s2[8];
   assign host.data = st.s2[7:0];
endmodule : cdh_sync
`default_nettype wire

// >>> logic/cdh_period.sv
// Sample-period timer: one-cycle start tick and a late capture tick.
// Stands in for the internal conversion clock.
`timescale 1ns/10ps
`default_nettype none
module cdh_period #(
   parameter int PERIOD = cdh_pkg::SAMPLE_PERIOD_CYCLES,
   parameter int LATE = cdh_pkg::CAPTURE_PHASE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Ticks
   output logic start_tick,
   output logic late_tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic start;
      logic late;
   } cdh_period_t;
   cdh_period_t st;
   cdh_period_t next_st;

   if (PERIOD < 4 || PERIOD > 65535 || LATE < 1 || LATE >= PERIOD) begin : g_bad
      $error("cdh_period: bad PERIOD or LATE");
   end

   always_comb begin
      next_st = st;
      next_st.cnt = (st.cnt == 16'(PERIOD - 1)) ? 16'h0000 : st.cnt + 16'h0001;
      next_st.start = (next_st.cnt == 16'h0000);
      next_st.late = (next_st.cnt == 16'(LATE));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign start_tick = st.start;
   assign late_tick = st.late;
endmodule : cdh_period
`default_nettype wire

// >>> logic/cdh_dma_top.sv
// DMA request/acknowledge core of a byte-wide audio codec, with APB registers.
// Assumes RST_N is the power-down pin; host strobes are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module cdh_dma_top
   import cdh_pkg::*;
#(
   parameter int BYTES = cdh_pkg::SAMPLE_BYTES,
   parameter int PERIOD = cdh_pkg::SAMPLE_PERIOD_CYCLES,
   parameter int CAL_BUSY = cdh_pkg::CAL_BUSY_PERIODS
) (
   // Clock and power-down reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Host DMA pins
   output logic PLAY_REQ,
   output logic CAP_REQ,
   input wire logic PLAY_ACK_N,
   input wire logic CAP_ACK_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   output logic IRQ,
   // Sample side
   input wire logic [31:0] CAP_SAMPLE,
   output logic [31:0] PLAY_SAMPLE,
   output logic PLAY_VALID,
   output logic PLAY_MUTE,
   output logic CAL_BUSY_OUT
);
   import cdh_pkg::*;

   localparam logic [1:0] LAST_BYTE = 2'(BYTES - 1);

   if (!(BYTES == 1 || BYTES == 2 || BYTES == 4) || CAL_BUSY < 1 || CAL_BUSY > 511) begin : g_bad
      $error("cdh_dma_top: unsupported BYTES or CAL_BUSY");
   end

   // The period timer counts in 16 bits
   if (PERIOD < 4 || PERIOD > 65535) begin : g_bad_period
      $error("cdh_dma_top: unsupported PERIOD");
   end

   typedef struct packed {
      logic [CFG_W-1:0] cfg;
      logic [7:0] base_lo;
      logic [7:0] base_hi;
      logic [15:0] cur;
      logic irq_status;
      logic irq_pin;
      logic [7:0] init_cnt;
      logic init_busy;
      cdh_cal_t cal;
      logic [8:0] cal_cnt;
      logic rd_prev;
      logic wr_prev;
      logic play_req;
      logic cap_req;
      logic [1:0] play_cnt;
      logic [1:0] cap_cnt;
      logic [31:0] play_buf;
      logic [31:0] cap_buf;
      logic [31:0] play_sample;
      logic play_valid;
      logic [7:0] data_out;
      logic data_oe;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic play_pin;
      logic cap_pin;
      logic mute;
      logic cal_busy;
   } cdh_state_t;

   cdh_state_t st;
   cdh_state_t next_st;
   logic start_tick;
   logic late_tick;
   cdh_host_if host ();

   // Host pins pass two flops before use
   cdh_sync u_sync (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .rd_n(RD_N),
      .wr_n(WR_N),
      .play_ack_n(PLAY_ACK_N),
      .cap_ack_n(CAP_ACK_N),
      .data(DATA_IN),
      .host(host)
   );

   cdh_period #(
      .PERIOD(PERIOD),
      .LATE((PERIOD * 3) / 4)
   ) u_period (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .start_tick(start_tick),
      .late_tick(late_tick)
   );

   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr == CONFIG_OFFSET) || (addr == BASE_LOW_OFFSET) ||
               (addr == BASE_HIGH_OFFSET) || (addr == STATUS_OFFSET);
   endfunction : mapped

   logic playback_enable;
   logic capture_enable;
   logic single_channel_mode;
   logic play_dma;
   logic cap_dma;
   logic cal_active;
   logic cap_owner;
   logic play_ack;
   logic cap_ack;
   logic rd_fall;
   logic rd_rise;
   logic wr_fall;
   logic wr_rise;
   logic wr_access;
   logic rd_setup;
   logic [7:0] rd_byte;

   always_comb begin
      playback_enable = st.cfg[CFG_PLAYBACK_ENABLE];
      capture_enable = st.cfg[CFG_CAPTURE_ENABLE];
      single_channel_mode = st.cfg[CFG_SINGLE_CHANNEL_MODE];
      play_dma = playback_enable && !st.cfg[CFG_PLAYBACK_PIO_SELECT];
      cap_dma = capture_enable && !st.cfg[CFG_CAPTURE_PIO_SELECT] && !(single_channel_mode && playback_enable);
      cal_active = (st.cal != CAL_IDLE);
      // In single-channel mode the shared ack belongs to a pending capture
      cap_owner = single_channel_mode && (st.cap_req || st.cap_cnt != 2'b00);
      play_ack = !host.play_ack_n && !cap_owner;
      cap_ack = single_channel_mode ? (!host.play_ack_n && cap_owner) : !host.cap_ack_n;
      rd_fall = st.rd_prev && !host.rd_n;
      rd_rise = !st.rd_prev && host.rd_n;
      wr_fall = st.wr_prev && !host.wr_n;
      wr_rise = !st.wr_prev && host.wr_n;
      wr_access = PSEL && PENABLE && st.pready && PWRITE && !st.init_busy;
      rd_setup = PSEL && !PENABLE;
      rd_byte = st.cap_buf[8 * st.cap_cnt +: 8];
   end

   always_comb begin
      next_st = st;
      next_st.play_valid = 1'b0;
      next_st.rd_prev = host.rd_n;
      next_st.wr_prev = host.wr_n;

      // Power-up initialisation window
      if (st.init_busy) begin
         if (st.init_cnt == 8'(INIT_CYCLES - 1)) begin
            next_st.init_busy = 1'b0;
         end else begin
            next_st.init_cnt = st.init_cnt + 8'h01;
         end
      end

      // Calibration sequence, counted in sample periods
      if (start_tick) begin
         if (st.cal == CAL_WAIT) begin
            if (st.cal_cnt == 9'(CAL_RISE_PERIODS - 1)) begin
               next_st.cal = CAL_RUN;
               next_st.cal_cnt = 9'h000;
            end else begin
               next_st.cal_cnt = st.cal_cnt + 9'h001;
            end
         end else if (st.cal == CAL_RUN) begin
            if (st.cal_cnt == 9'(CAL_BUSY - 1)) begin
               next_st.cal = CAL_IDLE;
            end else begin
               next_st.cal_cnt = st.cal_cnt + 9'h001;
            end
         end
      end

      // Request generation; pending requests survive an enable clear
      if (start_tick && play_dma && !cal_active && !st.init_busy) begin
         next_st.play_req = 1'b1;
      end
      if (late_tick && cap_dma && !cal_active && !st.init_busy && !st.cap_req) begin
         next_st.cap_req = 1'b1;
         next_st.cap_buf = cal_active ? 32'h0000_0000 : CAP_SAMPLE;
      end

      // Playback bytes: the last byte's strobe fall ends the request, each rise latches data
      if (play_ack && wr_fall && st.play_cnt == LAST_BYTE) begin
         next_st.play_req = 1'b0;
      end
      if (play_ack && wr_rise) begin
         next_st.play_buf[8 * st.play_cnt +: 8] = host.data;
         if (st.play_cnt == LAST_BYTE) begin
            next_st.play_cnt = 2'b00;
            next_st.play_sample = next_st.play_buf;
            next_st.play_valid = !cal_active;
         end else begin
            next_st.play_cnt = st.play_cnt + 2'b01;
         end
      end

      // Capture bytes: framed by the read strobe only
      if (cap_ack && rd_fall && st.cap_cnt == LAST_BYTE) begin
         next_st.cap_req = 1'b0;
      end
      if (cap_ack && rd_rise) begin
         next_st.cap_cnt = (st.cap_cnt == LAST_BYTE) ? 2'b00 : st.cap_cnt + 2'b01;
      end
      next_st.data_oe = cap_ack && !host.rd_n;
      next_st.data_out = rd_byte;

      // Sample counter and interrupt status
      if (start_tick && (playback_enable || capture_enable) &&
          (!st.cfg[CFG_REQUEST_HOLD_DISABLE] || !st.irq_status)) begin
         if (st.cur == 16'h0000) begin
            next_st.irq_status = 1'b1;
            next_st.cur = {st.base_hi, st.base_lo};
         end else begin
            next_st.cur = st.cur - 16'h0001;
         end
      end

      // APB writes take effect in the access cycle
      if (wr_access) begin
         if (PADDR == CONFIG_OFFSET) begin
            next_st.cfg = PWDATA[CFG_W-1:0];
            if (st.cfg[CFG_MODE_CHANGE_WINDOW] && !PWDATA[CFG_MODE_CHANGE_WINDOW] &&
                PWDATA[CFG_CALIBRATE_REQUEST]) begin
               next_st.cal = CAL_WAIT;
               next_st.cal_cnt = 9'h000;
            end
         end else if (PADDR == BASE_LOW_OFFSET) begin
            next_st.base_lo = PWDATA[7:0];
         end else if (PADDR == BASE_HIGH_OFFSET) begin
            next_st.base_hi = PWDATA[7:0];
            next_st.cur = {PWDATA[7:0], st.base_lo};
         end else if (PADDR == STATUS_OFFSET) begin
            // A same-cycle underflow keeps the bit set
            next_st.irq_status = next_st.irq_status && (st.cur == 16'h0000) && start_tick &&
                                 (playback_enable || capture_enable) &&
                                 (!st.cfg[CFG_REQUEST_HOLD_DISABLE] || !st.irq_status);
         end
      end
      next_st.irq_pin = next_st.irq_status && next_st.cfg[CFG_IRQ_PIN_ENABLE];

      // APB answer: zero wait states, data captured in setup
      next_st.pready = rd_setup;
      next_st.pslverr = rd_setup && !mapped(PADDR);
      next_st.prdata = 32'h0000_0000;
      if (rd_setup) begin
         if (st.init_busy) begin
            next_st.prdata = {24'h00_0000, BUSY_CODE};
         end else if (PADDR == CONFIG_OFFSET) begin
            next_st.prdata = {{(32 - CFG_W){1'b0}}, st.cfg};
         end else if (PADDR == BASE_LOW_OFFSET) begin
            next_st.prdata = {24'h00_0000, st.base_lo};
         end else if (PADDR == BASE_HIGH_OFFSET) begin
            next_st.prdata = {24'h00_0000, st.base_hi};
         end else if (PADDR == STATUS_OFFSET) begin
            next_st.prdata[STS_IRQ] = st.irq_status;
            next_st.prdata[STS_CALIBRATION_BUSY] = (st.cal == CAL_RUN);
            next_st.prdata[STS_PLAYBACK_REQUEST] = st.play_req;
            next_st.prdata[STS_CAPTURE_REQUEST] = st.cap_req;
         end
      end

      // Pin levels registered so every output leaves a flop
      next_st.play_pin = next_st.play_req ||
                         (next_st.cfg[CFG_SINGLE_CHANNEL_MODE] && next_st.cap_req);
      next_st.cap_pin = next_st.cap_req && !next_st.cfg[CFG_SINGLE_CHANNEL_MODE];
      // Mute covers the wait before busy rises as well
      next_st.mute = (next_st.cal != CAL_IDLE);
      next_st.cal_busy = (next_st.cal == CAL_RUN);
   end

   // Power-down holds everything idle with the data bus released
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st <= '0;
         st.cfg <= CFG_RESET;
         st.base_lo <= BASE_RESET;
         st.base_hi <= BASE_RESET;
         st.init_busy <= 1'b1;
         st.cal <= CAL_IDLE;
         st.rd_prev <= 1'b1;
         st.wr_prev <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign PRDATA = st.prdata;
   assign PREADY = st.pready;
   assign PSLVERR = st.pslverr;
   assign PLAY_REQ = st.play_pin;
   assign CAP_REQ = st.cap_pin;
   assign DATA_OUT = st.data_out;
   assign DATA_OE = st.data_oe;
   assign IRQ = st.irq_pin;
   assign PLAY_SAMPLE = st.play_sample;
   assign PLAY_VALID = st.play_valid;
   assign PLAY_MUTE = st.mute;
   assign CAL_BUSY_OUT = st.cal_busy;
endmodule : cdh_dma_top
`default_nettype wire

// >>> tb/cdh_host_model.sv
// Host DMA controller model: acknowledges a request and moves one four-byte sample.
// Assumes the block's level requests and its registered capture byte.
`timescale 1ns/10ps
`default_nettype none
module cdh_host_model (
   // Clock
   input wire logic clk,
   // Block pins
   input wire logic play_req,
   input wire logic cap_req,
   input wire logic [7:0] data_out,
   output logic play_ack_n,
   output logic cap_ack_n,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] data_in,
   // Bench side
   input wire logic play_dir,
   input wire logic slow,
   input wire logic [31:0] play_word,
   output logic play_taken,
   output logic cap_done,
   output logic [31:0] cap_word
);
   task automatic serve(input logic on_play, input logic wr);
      logic [31:0] w;
      w = play_word;
      repeat (slow ? 30 : 2) @(posedge clk);
      if (on_play) play_ack_n <= 1'b0;
      else cap_ack_n <= 1'b0;
      play_taken <= wr;
      @(posedge clk);
      play_taken <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (wr) begin
            wr_n <= 1'b0;
            data_in <= w[8*i +: 8];
         end else rd_n <= 1'b0;
         repeat (5) @(posedge clk);
         cap_word[8*i +: 8] <= data_out;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         repeat (2) @(posedge clk);
         // Released bus shows no stale byte
         data_in <= ~data_in;
         repeat (3) @(posedge clk);
      end
      play_ack_n <= 1'b1;
      cap_ack_n <= 1'b1;
      cap_done <= !wr;
      @(posedge clk);
      cap_done <= 1'b0;
   endtask : serve

   initial begin
      play_ack_n = 1'b1;
      cap_ack_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data_in = 8'h00;
      play_taken = 1'b0;
      cap_done = 1'b0;
      cap_word = 32'h0;
      forever begin
         @(posedge clk);
         // Pending requests are served even after the enable drops
         if (play_req === 1'b1) serve(1'b1, play_dir);
         else if (cap_req === 1'b1) serve(1'b0, 1'b0);
      end
   end
endmodule : cdh_host_model
`default_nettype wire

// >>> tb/cdh_dma_props.sv
// Port-level assertions for the DMA handshake block.
// Assumes PERIOD of at most 200 so five periods fit the window.
`timescale 1ns/10ps
`default_nettype none
module cdh_dma_props
   import cdh_pkg::*;
#(
   parameter int PERIOD = 200
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic PLAY_REQ,
   input wire logic CAP_REQ,
   input wire logic PLAY_ACK_N,
   input wire logic CAP_ACK_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic DATA_OE,
   input wire logic IRQ,
   input wire logic PLAY_MUTE,
   input wire logic CAL_BUSY_OUT
);
   localparam int CAL_WIN = 1000;
   logic [7:0] cyc;
   logic mcw;
   logic wacc;
   assign wacc = PSEL && PENABLE && PREADY && PWRITE;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cyc <= 8'h00;
         mcw <= 1'b0;
      end else begin
         if (cyc != 8'hFF) cyc <= cyc + 8'h01;
         if (wacc && PADDR == CONFIG_OFFSET && cyc == 8'hFF) mcw <= PWDATA[CFG_MODE_CHANGE_WINDOW];
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   a_reset_idle: assert property (cyc == 8'h00 |-> !PLAY_REQ && !CAP_REQ && !IRQ && !DATA_OE)
      else $error("outputs not idle after power-down");
   a_init_busy: assert property (PREADY && !PWRITE && PADDR == CONFIG_OFFSET && cyc < INIT_CYCLES - 5
      |-> PRDATA == 32'h80)
      else $error("init read not busy code");
   a_apb_ready: assert property (PSEL && $rose(PENABLE) |-> PREADY ##1 !PREADY)
      else $error("apb answer not one cycle");
   a_unmapped_err: assert property (PSEL && !PENABLE && PADDR > STATUS_OFFSET |=> PSLVERR)
      else $error("unmapped access without error");
   a_play_hold: assert property (PLAY_REQ && PLAY_ACK_N && RD_N && WR_N |=> PLAY_REQ)
      else $error("playback request dropped unserved");
   a_cap_hold: assert property (CAP_REQ && CAP_ACK_N && RD_N && WR_N |=> CAP_REQ)
      else $error("capture request dropped unserved");
   a_cal_noreq: assert property (CAL_BUSY_OUT |-> !$rose(PLAY_REQ) && !$rose(CAP_REQ))
      else $error("request raised during calibration");
   a_cal_mute: assert property (CAL_BUSY_OUT |-> PLAY_MUTE)
      else $error("playback not muted in calibration");
   a_oe_read: assert property ($rose(DATA_OE) |-> !RD_N)
      else $error("data driven without read strobe");
   a_irq_clear: assert property (wacc && PADDR == STATUS_OFFSET && IRQ |=> ##1 !IRQ)
      else $error("interrupt pin not cleared");
   a_cal_start: assert property (wacc && PADDR == CONFIG_OFFSET && cyc == 8'hFF && mcw
      && !PWDATA[CFG_MODE_CHANGE_WINDOW] && PWDATA[CFG_CALIBRATE_REQUEST] |-> ##[1:CAL_WIN] CAL_BUSY_OUT)
      else $error("calibration busy late");
endmodule : cdh_dma_props
bind cdh_dma_top cdh_dma_props #(.PERIOD(PERIOD)) i_cdh_dma_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .PLAY_REQ(PLAY_REQ), .CAP_REQ(CAP_REQ), .PLAY_ACK_N(PLAY_ACK_N),
   .CAP_ACK_N(CAP_ACK_N), .RD_N(RD_N), .WR_N(WR_N), .DATA_OE(DATA_OE), .IRQ(IRQ), .PLAY_MUTE(PLAY_MUTE),
   .CAL_BUSY_OUT(CAL_BUSY_OUT));
`default_nettype wire

// >>> tb/tb_cdh_dma_top.sv
// Self-checking bench: APB master, host DMA model, sample queues.
// Short period and calibration counts keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module tb_cdh_dma_top;
   import cdh_pkg::*;
   localparam int P = 200;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, slow = 1'b0;
   logic dir = 1'b1, sc_cap = 1'b0, cap_hi = 1'b0, cap_d = 1'b0, pl_d = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q, cap_sample = 32'h0, play_word = 32'h0;
   logic [31:0] play_q[$], cap_q[$];
   wire logic [31:0] prdata, play_sample, cap_word;
   wire logic pready, pslverr, play_req, cap_req, play_ack_n, cap_ack_n, rd_n, wr_n;
   wire logic data_oe, irq, play_valid, play_mute, cal_busy, play_taken, cap_done;
   wire logic [7:0] data_in, data_out;
   int mismatches = 0, n_tests = 0, cyc = 0, t0, i, seed;
   always #10 clk = ~clk;
   cdh_dma_top #(.PERIOD(P), .CAL_BUSY(4)) i_cdh_dma_top (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PLAY_REQ(play_req), .CAP_REQ(cap_req), .PLAY_ACK_N(play_ack_n),
      .CAP_ACK_N(cap_ack_n), .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(data_in), .DATA_OUT(data_out),
      .DATA_OE(data_oe), .IRQ(irq), .CAP_SAMPLE(cap_sample), .PLAY_SAMPLE(play_sample),
      .PLAY_VALID(play_valid), .PLAY_MUTE(play_mute), .CAL_BUSY_OUT(cal_busy));
   cdh_host_model i_cdh_host_model (.clk(clk), .play_req(play_req), .cap_req(cap_req), .data_out(data_out),
      .play_ack_n(play_ack_n), .cap_ack_n(cap_ack_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
      .play_dir(dir), .slow(slow), .play_word(play_word), .play_taken(play_taken), .cap_done(cap_done),
      .cap_word(cap_word));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      n_tests++;
      if (s !== x) begin
         $display("ERROR %s expected %h seen %h", n, x, s);
         mismatches++;
      end
   endtask : chk
   task conclude;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   always @(posedge clk) begin
      cyc <= cyc + 1;
      cap_d <= cap_req;
      pl_d <= play_req;
      if (cap_req === 1'b1) cap_hi <= 1'b1;
      if (play_taken === 1'b1) begin
         play_q.push_back(play_word);
         play_word <= $urandom;
      end
      if ((cap_req === 1'b1 && !cap_d) || (sc_cap && play_req === 1'b1 && !pl_d)) begin
         cap_q.push_back(cap_sample);
         cap_sample <= $urandom;
      end
      if (play_valid === 1'b1) chk("play_sample", play_q.pop_front(), play_sample);
      if (cap_done === 1'b1) chk("cap_word", cap_q.pop_front(), cap_word);
      if (cyc == 60000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      seed = $urandom(32'h40D80150);
      play_word = $urandom;
      cap_sample = $urandom;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b1, CONFIG_OFFSET, 32'h1FF);
      apb(1'b0, CONFIG_OFFSET, 32'h0);
      chk("init_code", 32'h80, q);
      for (i = 0; i < 60 && q === 32'h80; i++) apb(1'b0, CONFIG_OFFSET, 32'h0);
      chk("config_reset", {23'h0, CFG_RESET}, q);
      apb(1'b0, BASE_HIGH_OFFSET, 32'h0);
      chk("base_high_reset", 32'h0, q);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      apb(1'b1, BASE_LOW_OFFSET, 32'h02);
      apb(1'b1, BASE_HIGH_OFFSET, 32'h00);
      apb(1'b0, BASE_LOW_OFFSET, 32'h0);
      chk("base_low", 32'h02, q);
      $display("test registers done");
      t0 = cyc;
      apb(1'b1, CONFIG_OFFSET, 32'hA1);
      for (i = 0; i < 6 * P && irq !== 1'b1; i++) @(posedge clk);
      chk("irq_time", 32'h1, {31'h0, cyc - t0 >= 2 * P && cyc - t0 <= 4 * P + 20});
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("irq_status", 32'h1, {31'h0, q[STS_IRQ]});
      apb(1'b1, STATUS_OFFSET, 32'h0);
      repeat (3) @(posedge clk);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      slow <= 1'b1;
      apb(1'b1, CONFIG_OFFSET, 32'h81);
      repeat (4 * P) @(posedge clk);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("irq_reloaded", 32'h1, {31'h0, q[STS_IRQ]});
      chk("irq_masked", 32'h0, {31'h0, irq});
      for (i = 0; i < 2 * P && play_req !== 1'b1; i++) @(posedge clk);
      apb(1'b1, CONFIG_OFFSET, 32'hC0);
      repeat (3 * P) @(posedge clk);
      chk("play_abort", 32'h0, {31'h0, play_req});
      chk("play_drained", 32'h0, play_q.size());
      $display("test playback done");
      slow <= 1'b0;
      apb(1'b1, CONFIG_OFFSET, 32'h42);
      repeat (3 * P) @(posedge clk);
      apb(1'b1, CONFIG_OFFSET, 32'hC0);
      repeat (2 * P) @(posedge clk);
      chk("cap_drained", 32'h0, cap_q.size());
      $display("test capture done");
      apb(1'b1, CONFIG_OFFSET, 32'h04);
      dir <= 1'b0;
      sc_cap <= 1'b1;
      cap_hi <= 1'b0;
      apb(1'b1, CONFIG_OFFSET, 32'h06);
      repeat (3 * P) @(posedge clk);
      apb(1'b1, CONFIG_OFFSET, 32'h04);
      repeat (2 * P) @(posedge clk);
      chk("cap_req_low", 32'h0, {31'h0, cap_hi});
      chk("sc_cap_drained", 32'h0, cap_q.size());
      sc_cap <= 1'b0;
      dir <= 1'b1;
      apb(1'b1, CONFIG_OFFSET, 32'h07);
      repeat (3 * P) @(posedge clk);
      apb(1'b1, CONFIG_OFFSET, 32'h04);
      repeat (2 * P) @(posedge clk);
      chk("sc_play_drained", 32'h0, play_q.size());
      $display("test single channel done");
      apb(1'b1, CONFIG_OFFSET, 32'h100);
      apb(1'b1, CONFIG_OFFSET, 32'h009);
      for (i = 0; i < 6 * P && cal_busy !== 1'b1; i++) @(posedge clk);
      t0 = cyc;
      for (i = 0; i < 8 * P && cal_busy !== 1'b0; i++) @(posedge clk);
      chk("cal_time", 32'h1, {31'h0, cyc - t0 >= 3 * P && cyc - t0 <= 5 * P});
      repeat (3 * P) @(posedge clk);
      apb(1'b1, CONFIG_OFFSET, 32'hC0);
      repeat (2 * P) @(posedge clk);
      chk("cal_play_drained", 32'h0, play_q.size());
      $display("test calibration done");
      conclude();
   end
endmodule : tb_cdh_dma_top
`default_nettype wire
